// File: rtl/ccg_debounce.sv
`timescale 1ns/1ps
`include "ccg_defs.svh"

module ccg_debounce
    import ccg_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = `CCG_DEBOUNCE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw_n,
    output logic clean_n
);

    ccg_deb_state_type state_reg;
    ccg_deb_state_type state_next;

    if (STABLE_CYCLES < 1) begin : g_check
        $error("ccg_debounce: STABLE_CYCLES must be at least one");
    end

    // =====================================================
    // Two-stage synchroniser, then stability counter
    always_comb begin
        state_next = state_reg;
        state_next.sync_1 = raw_n;
        state_next.sync_2 = state_reg.sync_1;
        if (state_reg.sync_2 != state_reg.clean_n) begin
            if (state_reg.cnt >= STABLE_CYCLES - 1) begin
                state_next.clean_n = state_reg.sync_2;
                state_next.cnt = 32'h0;
            end else begin
                state_next.cnt = state_reg.cnt + 32'h1;
            end
        end else begin
            state_next.cnt = 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Idle-high so an unasserted pin never acts after reset
            state_reg <= '{sync_1: 1'b1, sync_2: 1'b1, clean_n: 1'b1, cnt: 32'h0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign clean_n = state_reg.clean_n;

endmodule

// File: rtl/ccg_defs.svh
// Operation
// - Source output high primary, low backup
// - Primary fault output low from fault until fault reset
// - Backup fault output low from fault until fault reset
// - Mode output high manual, low automatic
// - Power fault output low on power fault
// - Manual request low selects manual mode
// - Automatic request low selects automatic mode
// - Fault reset low clears latched faults
// - Configurable fault low for selected faults or watchdog reboot
// - Primary select low selects primary source
// - Backup select low selects backup source
// - Two trigger outputs follow primary, backup triggers
// - Timecode channel one direction configurable; others output
// - Panel enable toggled after 3 s hold; beep, lamp
// - Panel source buttons accepted only in manual
// - Lamp test lights each lamp alone
`ifndef CCG_DEFS_SVH
`define CCG_DEFS_SVH

// =====================================================
// Timing
`define CCG_CLK_HZ 40000000
`define CCG_CYCLES_PER_MS (`CCG_CLK_HZ / 1000)
`define CCG_DEBOUNCE_TIME_MS 10
`define CCG_HOLD_TIME_MS 3000
`define CCG_BEEP_TIME_MS 100
`define CCG_LAMP_STEP_TIME_MS 500
`define CCG_DEBOUNCE_CYCLES (`CCG_DEBOUNCE_TIME_MS * `CCG_CYCLES_PER_MS)
`define CCG_HOLD_CYCLES (`CCG_HOLD_TIME_MS * `CCG_CYCLES_PER_MS)
`define CCG_BEEP_CYCLES (`CCG_BEEP_TIME_MS * `CCG_CYCLES_PER_MS)
`define CCG_LAMP_STEP_CYCLES (`CCG_LAMP_STEP_TIME_MS * `CCG_CYCLES_PER_MS)

// =====================================================
// Fault bit positions
`define CCG_FLT_PRIMARY 0
`define CCG_FLT_BACKUP 1
`define CCG_FLT_POWER 2
`define CCG_FLT_COUNT 3

// =====================================================
// Control input positions (active low pins)
`define CCG_IN_MANUAL 0
`define CCG_IN_AUTO 1
`define CCG_IN_RESET 2
`define CCG_IN_PRIMARY 3
`define CCG_IN_BACKUP 4
`define CCG_IN_COUNT 5

// =====================================================
// Panel lamp positions
`define CCG_LAMP_ENABLE 0
`define CCG_LAMP_RESET 1
`define CCG_LAMP_AUTO 2
`define CCG_LAMP_MANUAL 3
`define CCG_LAMP_PRIMARY 4
`define CCG_LAMP_BACKUP 5
`define CCG_LAMP_PFAULT 6
`define CCG_LAMP_BFAULT 7
`define CCG_LAMP_COUNT 8
`define CCG_LAMP_LAST 3'h7

// =====================================================
// Reset values
`define CCG_RST_MANUAL 1'b0
`define CCG_RST_PRIMARY 1'b1

`endif

// File: rtl/ccg_gpio.sv
`timescale 1ns/1ps
`include "ccg_defs.svh"

module ccg_gpio
    import ccg_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = `CCG_DEBOUNCE_CYCLES,
    parameter int unsigned HOLD_CYCLES = `CCG_HOLD_CYCLES,
    parameter int unsigned BEEP_CYCLES = `CCG_BEEP_CYCLES,
    parameter int unsigned LAMP_STEP_CYCLES = `CCG_LAMP_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    // Remote control pins, active low, pulled up
    input wire logic manual_req_n,
    input wire logic auto_req_n,
    input wire logic fault_reset_n,
    input wire logic primary_sel_n,
    input wire logic backup_sel_n,
    // Internal fault and status sources
    input wire logic primary_fault_in,
    input wire logic backup_fault_in,
    input wire logic power_fault_in,
    input wire logic watchdog_reboot,
    input wire logic [2:0] fault_event_selection,
    // Remote status pins
    output logic source_state,
    output logic primary_fault_n,
    output logic backup_fault_n,
    output logic mode_state,
    output logic power_fault_n,
    output logic cfg_fault_n,
    // Trigger inputs and outputs
    input wire logic primary_trigger_in,
    input wire logic backup_trigger_in,
    output logic primary_trigger_out,
    output logic backup_trigger_out,
    // Timecode channels
    input wire logic tc1_dir_output,
    input wire logic [3:0] tc_gen,
    input wire logic timecode_channel_one_in,
    output logic timecode_channel_one_out,
    output logic timecode_channel_one_oe,
    output logic timecode_channel_one_rx,
    output logic [2:0] tc_other_out,
    // Front panel keys, active high from the key scanner
    input wire logic panel_enable_btn,
    input wire logic panel_reset_btn,
    input wire logic panel_auto_btn,
    input wire logic panel_manual_btn,
    input wire logic panel_primary_btn,
    input wire logic panel_backup_btn,
    input wire logic panel_lamp_test,
    // Front panel indicators
    output logic panel_enabled,
    output logic beep,
    output logic [7:0] panel_lamps
);

    // =====================================================
    // Elaboration checks
    if (HOLD_CYCLES < 1) begin : g_chk_hold
        $error("ccg_gpio: HOLD_CYCLES must be at least one");
    end
    if (BEEP_CYCLES < 1) begin : g_chk_beep
        $error("ccg_gpio: BEEP_CYCLES must be at least one");
    end
    if (LAMP_STEP_CYCLES < 1) begin : g_chk_lamp
        $error("ccg_gpio: LAMP_STEP_CYCLES must be at least one");
    end

    // =====================================================
    // Input conditioning
    logic [`CCG_IN_COUNT-1:0] pins_raw_n;
    logic [`CCG_IN_COUNT-1:0] pins_clean_n;

    assign pins_raw_n[`CCG_IN_MANUAL] = manual_req_n;
    assign pins_raw_n[`CCG_IN_AUTO] = auto_req_n;
    assign pins_raw_n[`CCG_IN_RESET] = fault_reset_n;
    assign pins_raw_n[`CCG_IN_PRIMARY] = primary_sel_n;
    assign pins_raw_n[`CCG_IN_BACKUP] = backup_sel_n;

    for (genvar i = 0; i < `CCG_IN_COUNT; i++) begin : g_deb
        ccg_debounce #(
            .STABLE_CYCLES(DEBOUNCE_CYCLES)
        ) u_deb (
            .clk(clk),
            .rst_n(rst_n),
            .raw_n(pins_raw_n[i]),
            .clean_n(pins_clean_n[i])
        );
    end

    // =====================================================
    // State
    ccg_state_type state_reg;
    ccg_state_type state_next;

    logic [4:0] btn_now;
    logic [4:0] btn_press;
    logic pin_manual;
    logic pin_auto;
    logic pin_reset;
    logic pin_primary;
    logic pin_backup;
    logic want_manual;
    logic want_auto;
    logic want_primary;
    logic want_backup;
    logic clear_faults;
    logic [2:0] fault_raw;
    logic [2:0] fault_now;
    logic hold_done;

    assign btn_now = {panel_backup_btn, panel_primary_btn, panel_manual_btn,
                      panel_auto_btn, panel_reset_btn};
    assign btn_press = btn_now & ~state_reg.btn_prev;

    assign pin_manual = ~pins_clean_n[`CCG_IN_MANUAL];
    assign pin_auto = ~pins_clean_n[`CCG_IN_AUTO];
    assign pin_reset = ~pins_clean_n[`CCG_IN_RESET];
    assign pin_primary = ~pins_clean_n[`CCG_IN_PRIMARY];
    assign pin_backup = ~pins_clean_n[`CCG_IN_BACKUP];

    assign fault_raw[`CCG_FLT_PRIMARY] = primary_fault_in;
    assign fault_raw[`CCG_FLT_BACKUP] = backup_fault_in;
    assign fault_raw[`CCG_FLT_POWER] = power_fault_in;

    assign hold_done = (state_reg.hold_cnt == HOLD_CYCLES);

    // =====================================================
    // Request decoding
    always_comb begin
        // Conflicting mode requests leave the mode as it is
        want_manual = (pin_manual & ~pin_auto) |
                      (state_reg.panel_en & btn_press[2] & ~btn_press[1]);
        want_auto = (pin_auto & ~pin_manual) |
                    (state_reg.panel_en & btn_press[1] & ~btn_press[2]);
        want_primary = (pin_primary & ~pin_backup) |
                       (state_reg.panel_en & state_reg.manual_mode &
                        btn_press[3] & ~btn_press[4]);
        want_backup = (pin_backup & ~pin_primary) |
                      (state_reg.panel_en & state_reg.manual_mode &
                       btn_press[4] & ~btn_press[3]);
        clear_faults = pin_reset | (state_reg.panel_en & btn_press[0]);
    end

    // =====================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.btn_prev = btn_now;

        // Mode and source selection
        if (want_manual && !want_auto) begin
            state_next.manual_mode = 1'b1;
        end else if (want_auto && !want_manual) begin
            state_next.manual_mode = 1'b0;
        end
        if (want_primary && !want_backup) begin
            state_next.primary_sel = 1'b1;
        end else if (want_backup && !want_primary) begin
            state_next.primary_sel = 1'b0;
        end

        // Fault latches; a fault present in the clearing cycle stays set
        fault_now = (state_reg.fault_latch & ~{3{clear_faults}}) | fault_raw;
        state_next.fault_latch = fault_now;

        // Status pins
        state_next.source_state = state_next.primary_sel;
        state_next.mode_state = state_next.manual_mode;
        state_next.primary_fault_n = ~fault_now[`CCG_FLT_PRIMARY];
        state_next.backup_fault_n = ~fault_now[`CCG_FLT_BACKUP];
        state_next.power_fault_n = ~fault_now[`CCG_FLT_POWER];
        state_next.cfg_fault_n = ~(|(fault_now & fault_event_selection)) &
                                 ~watchdog_reboot;

        // Triggers and timecode
        state_next.primary_trig = primary_trigger_in;
        state_next.backup_trig = backup_trigger_in;
        state_next.tc1_oe = tc1_dir_output;
        state_next.tc1_out = tc1_dir_output & tc_gen[0];
        state_next.tc1_rx = ~tc1_dir_output & timecode_channel_one_in;
        state_next.tc_out = tc_gen[3:1];

        // Panel enable: hold the key for the full time to toggle
        // Count saturates so a key kept down toggles only once
        if (panel_enable_btn) begin
            if (!hold_done) begin
                state_next.hold_cnt = state_reg.hold_cnt + 32'h1;
            end
        end else begin
            state_next.hold_cnt = 32'h0;
        end
        if (panel_enable_btn && state_next.hold_cnt == HOLD_CYCLES && !hold_done) begin
            state_next.panel_en = ~state_reg.panel_en;
            state_next.beep = 1'b1;
            state_next.beep_cnt = BEEP_CYCLES - 1;
        end else if (state_reg.beep) begin
            if (state_reg.beep_cnt == 32'h0) begin
                state_next.beep = 1'b0;
            end else begin
                state_next.beep_cnt = state_reg.beep_cnt - 32'h1;
            end
        end

        // Lamp test walks a single lit lamp across the panel
        case (state_reg.test_state)
            CCG_TEST_IDLE: begin
                state_next.lamps = '0;
                state_next.lamps[`CCG_LAMP_ENABLE] = state_next.panel_en;
                state_next.lamps[`CCG_LAMP_RESET] = |fault_now;
                state_next.lamps[`CCG_LAMP_AUTO] = ~state_next.manual_mode;
                state_next.lamps[`CCG_LAMP_MANUAL] = state_next.manual_mode;
                state_next.lamps[`CCG_LAMP_PRIMARY] = state_next.primary_sel;
                state_next.lamps[`CCG_LAMP_BACKUP] = ~state_next.primary_sel;
                state_next.lamps[`CCG_LAMP_PFAULT] = fault_now[`CCG_FLT_PRIMARY];
                state_next.lamps[`CCG_LAMP_BFAULT] = fault_now[`CCG_FLT_BACKUP];
                if (panel_lamp_test) begin
                    state_next.test_state = CCG_TEST_RUN;
                    state_next.lamp_idx = 3'h0;
                    state_next.lamp_cnt = LAMP_STEP_CYCLES - 1;
                    state_next.lamps = 8'h01;
                end
            end
            CCG_TEST_RUN: begin
                if (!panel_lamp_test) begin
                    state_next.test_state = CCG_TEST_IDLE;
                    state_next.lamps = '0;
                end else if (state_reg.lamp_cnt == 32'h0) begin
                    if (state_reg.lamp_idx == `CCG_LAMP_LAST) begin
                        state_next.lamp_idx = 3'h0;
                    end else begin
                        state_next.lamp_idx = state_reg.lamp_idx + 3'h1;
                    end
                    state_next.lamp_cnt = LAMP_STEP_CYCLES - 1;
                    state_next.lamps = 8'h01 << state_next.lamp_idx;
                end else begin
                    state_next.lamp_cnt = state_reg.lamp_cnt - 32'h1;
                    state_next.lamps = 8'h01 << state_reg.lamp_idx;
                end
            end
            default: begin
                state_next.test_state = CCG_TEST_IDLE;
                state_next.lamps = '0;
            end
        endcase
    end

    // =====================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.manual_mode <= `CCG_RST_MANUAL;
            state_reg.primary_sel <= `CCG_RST_PRIMARY;
            state_reg.source_state <= `CCG_RST_PRIMARY;
            state_reg.mode_state <= `CCG_RST_MANUAL;
            state_reg.primary_fault_n <= 1'b1;
            state_reg.backup_fault_n <= 1'b1;
            state_reg.power_fault_n <= 1'b1;
            state_reg.cfg_fault_n <= 1'b1;
            state_reg.test_state <= CCG_TEST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // =====================================================
    // Outputs
    assign source_state = state_reg.source_state;
    assign primary_fault_n = state_reg.primary_fault_n;
    assign backup_fault_n = state_reg.backup_fault_n;
    assign mode_state = state_reg.mode_state;
    assign power_fault_n = state_reg.power_fault_n;
    assign cfg_fault_n = state_reg.cfg_fault_n;
    assign primary_trigger_out = state_reg.primary_trig;
    assign backup_trigger_out = state_reg.backup_trig;
    assign timecode_channel_one_out = state_reg.tc1_out;
    assign timecode_channel_one_oe = state_reg.tc1_oe;
    assign timecode_channel_one_rx = state_reg.tc1_rx;
    assign tc_other_out = state_reg.tc_out;
    assign panel_enabled = state_reg.panel_en;
    assign beep = state_reg.beep;
    assign panel_lamps = state_reg.lamps;

endmodule

// File: rtl/ccg_pkg.sv
package ccg_pkg;

    typedef logic [31:0] ccg_count_type;

    typedef enum logic [1:0] {
        CCG_TEST_IDLE,
        CCG_TEST_RUN
    } ccg_test_state_type;

    typedef struct packed {
        logic sync_1;
        logic sync_2;
        logic clean_n;
        ccg_count_type cnt;
    } ccg_deb_state_type;

    typedef struct packed {
        logic manual_mode;
        logic primary_sel;
        logic [2:0] fault_latch;
        logic source_state;
        logic mode_state;
        logic primary_fault_n;
        logic backup_fault_n;
        logic power_fault_n;
        logic cfg_fault_n;
        logic primary_trig;
        logic backup_trig;
        logic tc1_out;
        logic tc1_oe;
        logic tc1_rx;
        logic [2:0] tc_out;
        logic panel_en;
        ccg_count_type hold_cnt;
        ccg_count_type beep_cnt;
        logic beep;
        ccg_test_state_type test_state;
        logic [2:0] lamp_idx;
        ccg_count_type lamp_cnt;
        logic [7:0] lamps;
        logic [4:0] btn_prev;
    } ccg_state_type;

endpackage

// File: tb/ccg_properties.sv
`timescale 1ns/1ps
module ccg_properties #(
    parameter int unsigned DEBOUNCE_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic manual_req_n,
    input wire logic auto_req_n,
    input wire logic fault_reset_n,
    input wire logic primary_sel_n,
    input wire logic backup_sel_n,
    input wire logic primary_fault_in,
    input wire logic backup_fault_in,
    input wire logic power_fault_in,
    input wire logic watchdog_reboot,
    input wire logic [2:0] fault_event_selection,
    input wire logic source_state,
    input wire logic primary_fault_n,
    input wire logic backup_fault_n,
    input wire logic power_fault_n,
    input wire logic mode_state,
    input wire logic cfg_fault_n,
    input wire logic primary_trigger_in,
    input wire logic backup_trigger_in,
    input wire logic primary_trigger_out,
    input wire logic backup_trigger_out,
    input wire logic tc1_dir_output,
    input wire logic [3:0] tc_gen,
    input wire logic timecode_channel_one_oe,
    input wire logic [2:0] tc_other_out,
    input wire logic panel_lamp_test,
    input wire logic [7:0] panel_lamps
);
    // Slack after a request has been held past the debounce time
    localparam int SETTLE = DEBOUNCE_CYCLES + 4;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // =====================================================
    // Sequences
    sequence manual_held;
        (!manual_req_n && auto_req_n)[*8];
    endsequence
    sequence primary_held;
        (!primary_sel_n && backup_sel_n)[*8];
    endsequence
    sequence clear_held;
        (!fault_reset_n && !primary_fault_in && !backup_fault_in && !power_fault_in)[*8];
    endsequence
    sequence lamp_rise;
        !panel_lamp_test ##1 panel_lamp_test;
    endsequence
    // =====================================================
    // Properties
    manual_mode_a: assert property (manual_held |-> ##[0:SETTLE] mode_state)
        else $error("manual request not taken");
    primary_pick_a: assert property (primary_held |-> ##[0:SETTLE] source_state)
        else $error("primary select not taken");
    fault_clear_a: assert property (clear_held |-> ##[0:SETTLE]
        (primary_fault_n && backup_fault_n && power_fault_n))
        else $error("fault reset not taken");
    pfault_low_a: assert property (primary_fault_in |=> !primary_fault_n)
        else $error("primary fault not shown");
    bfault_low_a: assert property (backup_fault_in |=> !backup_fault_n)
        else $error("backup fault not shown");
    power_low_a: assert property (power_fault_in |=> !power_fault_n)
        else $error("power fault not shown");
    cfg_mask_a: assert property ((fault_event_selection == 3'h0 && !watchdog_reboot)
        |=> cfg_fault_n)
        else $error("unselected fault drives cfg output");
    reboot_cfg_a: assert property (watchdog_reboot |=> !cfg_fault_n)
        else $error("reboot not shown");
    trig_copy_a: assert property ($past(rst_n) |->
        (primary_trigger_out == $past(primary_trigger_in)
        && backup_trigger_out == $past(backup_trigger_in)))
        else $error("trigger outputs wrong");
    tc_dir_a: assert property ($past(rst_n) |->
        (timecode_channel_one_oe == $past(tc1_dir_output)
        && tc_other_out == 3'($past(tc_gen) >> 1)))
        else $error("timecode outputs wrong");
    lamp_first_a: assert property (lamp_rise |=> panel_lamps == 8'h01)
        else $error("lamp test start wrong");
    lamp_single_a: assert property ((panel_lamp_test && $past(panel_lamp_test))
        |-> $onehot(panel_lamps))
        else $error("lamp test lights several");
endmodule

bind ccg_gpio ccg_properties #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_props (
    .clk(clk), .rst_n(rst_n), .manual_req_n(manual_req_n), .auto_req_n(auto_req_n),
    .fault_reset_n(fault_reset_n), .primary_sel_n(primary_sel_n),
    .backup_sel_n(backup_sel_n), .primary_fault_in(primary_fault_in),
    .backup_fault_in(backup_fault_in), .power_fault_in(power_fault_in),
    .watchdog_reboot(watchdog_reboot), .fault_event_selection(fault_event_selection),
    .source_state(source_state), .primary_fault_n(primary_fault_n),
    .backup_fault_n(backup_fault_n), .power_fault_n(power_fault_n),
    .mode_state(mode_state), .cfg_fault_n(cfg_fault_n),
    .primary_trigger_in(primary_trigger_in), .backup_trigger_in(backup_trigger_in),
    .primary_trigger_out(primary_trigger_out), .backup_trigger_out(backup_trigger_out),
    .tc1_dir_output(tc1_dir_output), .tc_gen(tc_gen),
    .timecode_channel_one_oe(timecode_channel_one_oe), .tc_other_out(tc_other_out),
    .panel_lamp_test(panel_lamp_test), .panel_lamps(panel_lamps)
);

// File: tb/ccg_remote_model.sv
`timescale 1ns/1ps
module ccg_remote_model (
    input wire logic clk,
    input wire logic [4:0] cmd,
    output logic manual_req_n,
    output logic auto_req_n,
    output logic fault_reset_n,
    output logic primary_sel_n,
    output logic backup_sel_n
);
    // Released pins sit at the pull-up level
    logic [4:0] pin_n = 5'h1f;
    always @(posedge clk) begin
        pin_n <= ~cmd;
    end
    assign manual_req_n = pin_n[0];
    assign auto_req_n = pin_n[1];
    assign fault_reset_n = pin_n[2];
    assign primary_sel_n = pin_n[3];
    assign backup_sel_n = pin_n[4];
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk, rst_n, wd, pti, bti, dir, tc1_in;
    logic [4:0] cmd;
    logic [2:0] flt, sel;
    logic [3:0] tcg;
    logic [6:0] btn;
    logic man_n, aut_n, rst_req_n, psel_n, bsel_n;
    logic src, pfn, bfn, mode, pwn, cfgn, pto, bto, tco, tcoe, tcrx, pen, bp;
    logic [2:0] tco3;
    logic [7:0] lamps;
    int mismatches, checks, cyc, n;

    ccg_gpio #(.DEBOUNCE_CYCLES(4), .HOLD_CYCLES(20), .BEEP_CYCLES(5),
        .LAMP_STEP_CYCLES(3)) dut (
        .clk(clk), .rst_n(rst_n), .manual_req_n(man_n), .auto_req_n(aut_n),
        .fault_reset_n(rst_req_n), .primary_sel_n(psel_n), .backup_sel_n(bsel_n),
        .primary_fault_in(flt[0]), .backup_fault_in(flt[1]), .power_fault_in(flt[2]),
        .watchdog_reboot(wd), .fault_event_selection(sel), .source_state(src),
        .primary_fault_n(pfn), .backup_fault_n(bfn), .mode_state(mode),
        .power_fault_n(pwn), .cfg_fault_n(cfgn), .primary_trigger_in(pti),
        .backup_trigger_in(bti), .primary_trigger_out(pto), .backup_trigger_out(bto),
        .tc1_dir_output(dir), .tc_gen(tcg), .timecode_channel_one_in(tc1_in),
        .timecode_channel_one_out(tco), .timecode_channel_one_oe(tcoe),
        .timecode_channel_one_rx(tcrx), .tc_other_out(tco3),
        .panel_enable_btn(btn[0]), .panel_reset_btn(btn[1]), .panel_auto_btn(btn[2]),
        .panel_manual_btn(btn[3]), .panel_primary_btn(btn[4]),
        .panel_backup_btn(btn[5]), .panel_lamp_test(btn[6]),
        .panel_enabled(pen), .beep(bp), .panel_lamps(lamps));

    ccg_remote_model remote_side (
        .clk(clk), .cmd(cmd), .manual_req_n(man_n), .auto_req_n(aut_n),
        .fault_reset_n(rst_req_n), .primary_sel_n(psel_n), .backup_sel_n(bsel_n));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task remote(input logic [4:0] c, input int k);
        @(posedge clk) cmd <= c;
        tick(k);
    endtask

    // One key stroke from the scanner
    task press(input int b);
        @(posedge clk) btn[b] <= 1'b1;
        @(posedge clk) btn[b] <= 1'b0;
        tick(3);
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            $display("mismatch at %0t: run did not complete", $time);
            tally_and_finish();
        end
    end

    initial begin
        rst_n = 1'b0;
        cmd = 5'h00;
        flt = 3'h0;
        sel = 3'h0;
        wd = 1'b0;
        {pti, bti, dir, tc1_in} = 4'h0;
        tcg = 4'h0;
        btn = 7'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({src, mode, pfn, bfn, pwn, cfgn, pen, bp}, 8'hbc, "reset state");
        chk(lamps, 8'h00, "reset lamps");
        // =====================================================
        // Triggers and timecode
        @(posedge clk) {pti, tcg, dir, tc1_in} <= 7'h5b;
        tick(1);
        chk({pto, bto, tcoe, tco, tcrx, tco3}, 8'ha3, "trig tc out");
        @(posedge clk) {pti, bti, tcg, dir} <= 7'h2a;
        tick(1);
        chk({pto, bto, tcoe, tco, tcrx, tco3}, 8'h4a, "trig tc in");
        // =====================================================
        // Remote mode and source
        remote(5'h01, 14);
        chk(mode, 1'b1, "manual request");
        remote(5'h00, 1);
        remote(5'h02, 1);
        remote(5'h00, 14);
        chk(mode, 1'b1, "short glitch");
        remote(5'h02, 14);
        chk(mode, 1'b0, "auto request");
        remote(5'h10, 14);
        chk(src, 1'b0, "backup select");
        remote(5'h18, 14);
        chk(src, 1'b0, "both selects");
        remote(5'h08, 14);
        chk(src, 1'b1, "primary select");
        remote(5'h00, 1);
        // =====================================================
        // Faults
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) begin
                flt <= 3'h1 << i;
                sel <= 3'h1 << ((i + 1) % 3);
            end
            @(posedge clk) flt <= 3'h0;
            tick(2);
            chk({pwn, bfn, pfn}, 3'(~(3'h1 << i)), "latched fault");
            chk(cfgn, 1'b1, "unselected fault");
            @(posedge clk) sel <= 3'h1 << i;
            tick(2);
            chk(cfgn, 1'b0, "selected fault");
            remote(5'h04, 14);
            remote(5'h00, 8);
            chk({cfgn, pwn, bfn, pfn}, 4'hf, "fault reset");
        end
        @(posedge clk) begin
            sel <= 3'h0;
            wd <= 1'b1;
        end
        tick(2);
        chk(cfgn, 1'b0, "reboot");
        @(posedge clk) wd <= 1'b0;
        tick(2);
        chk(cfgn, 1'b1, "reboot over");
        // =====================================================
        // Front panel
        press(3);
        chk(mode, 1'b0, "panel locked");
        @(posedge clk) btn[0] <= 1'b1;
        n = 0;
        while (pen !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk(8'(n >= 20 && n <= 24), 8'h01, "hold time");
        chk({pen, bp, lamps[0]}, 3'h7, "panel enabled");
        @(posedge clk) btn[0] <= 1'b0;
        press(3);
        press(5);
        chk({mode, src}, 2'h2, "manual backup key");
        press(2);
        press(4);
        chk({mode, src}, 2'h0, "auto ignores key");
        @(posedge clk) btn[6] <= 1'b1;
        tick(1);
        for (int k = 0; k < 9; k++) begin
            chk(lamps, 8'h01 << (k % 8), "lamp walk");
            tick(3);
        end
        @(posedge clk) btn[6] <= 1'b0;
        tick(2);
        chk(lamps, 8'h25, "lamps normal");
        tally_and_finish();
    end
endmodule
